/* File: txm_pkg.sv */
// Purpose: Shared constants and types for the transmit control bank
// Assumes: One system clock; host port on the same clock
// Notes:   Channel index 0..11 maps from address upper nibble
package txm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int TXM_NCH = 12;            // Channels
    localparam int TXM_AW  = 8;             // Host address width
    localparam int TXM_DW  = 8;             // Host data width

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [3:0] TXM_TC_LOW     = 4'h4; // Low nibble of register
    localparam logic [3:0] TXM_BANK0_LAST = 4'h5; // Last nibble, first bank
    localparam logic [3:0] TXM_BANK1_FRST = 4'h8; // First nibble, 2nd bank
    localparam logic [3:0] TXM_BANK1_LAST = 4'hd; // Last nibble, 2nd bank
    localparam logic [3:0] TXM_BANK1_OFFS = 4'h2; // Nibble minus channel

    // ------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------
    localparam int         TXM_BIT_INTMON = 5;     // Internal monitor select
    localparam int         TXM_BIT_INSERR = 4;     // Error insert command
    localparam logic [7:0] TXM_WR_MASK    = 8'h37; // Writable bits
    localparam logic [7:0] TXM_TC_RESET   = 8'h00; // Reset value

    // Transmit control register fields
    typedef struct packed {
        logic [1:0] rsv_hi;   // Reserved, reads zero
        logic       int_mon;  // 1: watch own pads
        logic       ins_err;  // Rising edge injects one error
        logic       rsv_mid;  // Reserved, reads zero
        logic [2:0] low;      // All-ones, clock edge, build-out
    } txm_tc_s;

    // Decoded host address
    typedef struct packed {
        logic       hit;      // Address names a register
        logic [3:0] ch;       // Channel index
    } txm_sel_s;

    // ------------------------------------------------------------
    // Drive monitor timing
    // ------------------------------------------------------------
    localparam int         TXM_DMO_PERIODS = 128;  // Quiet bit periods
    localparam logic [7:0] TXM_DMO_LIMIT   = 8'(TXM_DMO_PERIODS);
    localparam logic [7:0] TXM_DMO_LAST    = TXM_DMO_LIMIT - 8'h01;
    localparam logic [7:0] TXM_CNT_STEP    = 8'h01;

    // Address to channel decode
    function automatic txm_sel_s txm_decode(input logic [TXM_AW-1:0] a);
        txm_sel_s s;
        s.hit = 1'b0;
        s.ch  = a[7:4];
        if (a[3:0] == TXM_TC_LOW) begin
            if (a[7:4] <= TXM_BANK0_LAST) begin
                s.hit = 1'b1;
            end else if (a[7:4] >= TXM_BANK1_FRST &&
                         a[7:4] <= TXM_BANK1_LAST) begin
                s.hit = 1'b1;
                s.ch  = a[7:4] - TXM_BANK1_OFFS;
            end
        end
        return s;
    endfunction

endpackage

/* File: txm_dmon.sv */
// Purpose: Per-channel transmit drive monitor alarm
// Assumes: bit_en is a one-cycle pulse per bit period
// Notes:   Pad and monitor pins are synchronised before use
`timescale 1ns/1ps

module txm_dmon
    import txm_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Control
    input  wire logic int_mon,
    input  wire logic bit_en,
    // Observed pins
    input  wire logic tx_pos,
    input  wire logic tx_neg,
    input  wire logic mon_pos,
    input  wire logic mon_neg,
    // Alarm
    output logic      alarm
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] s1_q;     // First stage, read by second only
    logic [3:0] s2_q;     // Second stage: tx_pos, tx_neg, mon_pos, mon_neg

    // Two-flop synchroniser
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
        end else begin
            s1_q <= {tx_pos, tx_neg, mon_pos, mon_neg};
            s2_q <= s1_q;
        end
    end

    // ------------------------------------------------------------
    // Quiet period counter
    // ------------------------------------------------------------
    logic       act_q, act_d;     // Pulse seen this bit period
    logic [7:0] cnt_q, cnt_d;     // Quiet bit periods
    logic       alarm_q, alarm_d; // Alarm state
    logic       act_now;          // Pulse on selected source
    logic       bip;              // Activity over the period

    // Next state
    always_comb begin
        // Source select: own pads or monitor pins
        act_now = int_mon ? (s2_q[3] | s2_q[2])      // RQ1 RQ2
                          : (s2_q[1] | s2_q[0]);     // RQ1
        bip     = act_q | act_now;
        act_d   = bit_en ? 1'b0 : bip;
        cnt_d   = cnt_q;
        alarm_d = alarm_q;
        if (bit_en) begin
            if (bip) begin
                // Activity clears the alarm
                cnt_d   = 8'h00;                     // RQ8
                alarm_d = 1'b0;                      // RQ8
            end else if (cnt_q != TXM_DMO_LIMIT) begin
                // Count quiet periods, saturate
                cnt_d = cnt_q + TXM_CNT_STEP;
                if (cnt_q == TXM_DMO_LAST) begin
                    alarm_d = 1'b1;                  // RQ8
                end
            end
        end
    end

    // Registers
    always_ff @(posedge clock) begin
        if (rst) begin
            act_q   <= 1'b0;
            cnt_q   <= 8'h00;
            alarm_q <= 1'b0;
        end else begin
            act_q   <= act_d;
            cnt_q   <= cnt_d;
            alarm_q <= alarm_d;
        end
    end

    assign alarm = alarm_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_ext_src;
        @(posedge clock) disable iff (rst)
        (!int_mon && bit_en && !act_q && !s2_q[1] && !s2_q[0] &&
         cnt_q < TXM_DMO_LIMIT) |=> (cnt_q == $past(cnt_q) + TXM_CNT_STEP);
    endproperty
    a_ext_src: assert property (p_ext_src) // RQ1
        else $error("external monitor quiet period not counted");

    property p_int_src;
        @(posedge clock) disable iff (rst)
        (int_mon && bit_en && (s2_q[3] || s2_q[2]))
            |=> (cnt_q == 8'h00 && !alarm);
    endproperty
    a_int_src: assert property (p_int_src) // RQ2
        else $error("pad activity did not clear monitor");

    property p_alarm_rise;
        @(posedge clock) disable iff (rst)
        $rose(alarm_q) |-> ($past(cnt_q) == TXM_DMO_LAST && $past(bit_en)
                            && cnt_q == TXM_DMO_LIMIT);
    endproperty
    a_alarm_rise: assert property (p_alarm_rise) // RQ8
        else $error("alarm raised at wrong quiet count");

endmodule

/* File: txm_tx_ctrl.sv */
// Purpose: Per-channel transmit control registers, monitor and error insert
// Assumes: Host port is synchronous to clock; strobes last one cycle
// Notes:   Reads return data one cycle after the read strobe
`timescale 1ns/1ps

// What this block does
// [RQ1] Bit 5 selects pads or monitor pins
// [RQ2] Internal mode needs no monitor pin connection
// [RQ3] Error bit rising edge corrupts one bit
// [RQ4] Error insert needs generator and receiver enabled
// [RQ5] Host clears error bit before next request
// [RQ6] Register per channel at 0xm4, m valid
// [RQ7] Reserved bits 7, 6, 3 read zero
// [RQ8] Alarm after 128 quiet bit periods
module txm_tx_ctrl
    import txm_pkg::*;
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Processor port
    input  wire logic [TXM_AW-1:0]      cpu_addr,
    input  wire logic                   cpu_wr,
    input  wire logic                   cpu_rd,
    input  wire logic [TXM_DW-1:0]      cpu_wdata,
    output logic      [TXM_DW-1:0]      cpu_rdata,
    output logic                        cpu_rvalid,
    // Per-channel pattern status
    input  wire logic [TXM_NCH-1:0]     prbs_gen_en,
    input  wire logic [TXM_NCH-1:0]     prbs_rx_en,
    input  wire logic [TXM_NCH-1:0]     bit_en,
    // Per-channel line pins
    input  wire logic [TXM_NCH-1:0]     tx_line_out_pos,
    input  wire logic [TXM_NCH-1:0]     tx_line_out_neg,
    input  wire logic [TXM_NCH-1:0]     monitor_in_pos,
    input  wire logic [TXM_NCH-1:0]     monitor_in_neg,
    // Per-channel results
    output logic      [TXM_NCH-1:0]     driver_monitor_alarm,
    output logic      [TXM_NCH-1:0]     prbs_err_inject,
    output logic      [TXM_NCH-1:0][2:0] tx_ctrl_low
);

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    txm_tc_s [TXM_NCH-1:0] regs_q, regs_d;   // Control registers
    logic    [TXM_NCH-1:0] inj_q, inj_d;     // Error insert pulses
    logic    [TXM_DW-1:0]  rdata_q, rdata_d; // Read data
    logic                  rval_q, rval_d;   // Read answer strobe
    txm_sel_s              wsel;             // Decoded address

    // Next state of bank and read path
    always_comb begin
        regs_d  = regs_q;
        inj_d   = '0;
        rdata_d = '0;
        rval_d  = cpu_rd;
        wsel    = txm_decode(cpu_addr);              // RQ6
        // Write: reserved bits dropped
        if (cpu_wr && wsel.hit) begin
            regs_d[wsel.ch] = txm_tc_s'(cpu_wdata & TXM_WR_MASK); // RQ7
            // Edge of error bit, gated by both enables
            inj_d[wsel.ch] = !regs_q[wsel.ch].ins_err &&
                             cpu_wdata[TXM_BIT_INSERR] &&   // RQ3 RQ5
                             prbs_gen_en[wsel.ch] &&
                             prbs_rx_en[wsel.ch];           // RQ4
        end
        // Read: unmapped addresses return zero
        if (cpu_rd && wsel.hit) begin
            rdata_d = regs_q[wsel.ch];                      // RQ6 RQ7
        end
    end

    // Bank registers
    always_ff @(posedge clock) begin
        if (rst) begin
            regs_q  <= {TXM_NCH{TXM_TC_RESET}};
            inj_q   <= '0;
            rdata_q <= '0;
            rval_q  <= 1'b0;
        end else begin
            regs_q  <= regs_d;
            inj_q   <= inj_d;
            rdata_q <= rdata_d;
            rval_q  <= rval_d;
        end
    end

    assign cpu_rdata       = rdata_q;
    assign cpu_rvalid      = rval_q;
    assign prbs_err_inject = inj_q;

    // ------------------------------------------------------------
    // Per-channel drive monitors
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < TXM_NCH; gi++) begin : g_ch
            // Low bits go straight to the transmit section
            assign tx_ctrl_low[gi] = regs_q[gi].low;

            // Alarm from selected source
            txm_dmon u_dmon (
                .clock   (clock),
                .rst     (rst),
                .int_mon (regs_q[gi].int_mon),     // RQ1
                .bit_en  (bit_en[gi]),
                .tx_pos  (tx_line_out_pos[gi]),
                .tx_neg  (tx_line_out_neg[gi]),
                .mon_pos (monitor_in_pos[gi]),
                .mon_neg (monitor_in_neg[gi]),
                .alarm   (driver_monitor_alarm[gi]) // RQ2 RQ8
            );

            // Injection only on a rising edge
            property p_inj_edge;
                @(posedge clock) disable iff (rst)
                inj_q[gi] |-> ($rose(regs_q[gi].ins_err) ##1 !inj_q[gi]);
            endproperty
            a_inj_edge: assert property (p_inj_edge) // RQ3
                else $error("error insert without rising edge");

            // Injection needs both enables
            property p_inj_gate;
                @(posedge clock) disable iff (rst)
                inj_q[gi] |-> $past(prbs_gen_en[gi] && prbs_rx_en[gi]);
            endproperty
            a_inj_gate: assert property (p_inj_gate) // RQ4
                else $error("error insert while pattern disabled");
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Write that names a register
    sequence s_valid_wr;
        cpu_wr && wsel.hit;
    endsequence

    // Write that raises the error bit with both enables on
    sequence s_inj_req;
        cpu_wr && wsel.hit && !regs_q[wsel.ch].ins_err &&
        cpu_wdata[TXM_BIT_INSERR] &&
        prbs_gen_en[wsel.ch] && prbs_rx_en[wsel.ch];
    endsequence

    // Write lands in the decoded channel, reserved bits dropped
    property p_wr_decode;
        @(posedge clock) disable iff (rst)
        s_valid_wr |=> (regs_q[$past(wsel.ch)] ==
                        ($past(cpu_wdata) & TXM_WR_MASK));
    endproperty
    a_wr_decode: assert property (p_wr_decode) // RQ6
        else $error("write did not reach decoded channel");

    // Nothing but a mapped write changes the bank
    property p_wr_miss;
        @(posedge clock) disable iff (rst)
        !(cpu_wr && wsel.hit) |=> $stable(regs_q);
    endproperty
    a_wr_miss: assert property (p_wr_miss) // RQ6
        else $error("bank changed without a mapped write");

    // Rising error bit with both enables gives a pulse
    property p_inj_take;
        @(posedge clock) disable iff (rst)
        s_inj_req |=> prbs_err_inject[$past(wsel.ch)];
    endproperty
    a_inj_take: assert property (p_inj_take) // RQ3
        else $error("error insert request gave no pulse");

    // Either enable low: no pulse at all
    property p_inj_refuse;
        @(posedge clock) disable iff (rst)
        (cpu_wr && wsel.hit &&
         !(prbs_gen_en[wsel.ch] && prbs_rx_en[wsel.ch]))
            |=> (prbs_err_inject == '0);
    endproperty
    a_inj_refuse: assert property (p_inj_refuse) // RQ4
        else $error("error insert pulse with pattern disabled");

    // ------------------------------------------------------------
    // Read path checks
    // ------------------------------------------------------------
    // Read answer exactly one cycle after the strobe
    property p_rd_answer;
        @(posedge clock) disable iff (rst)
        cpu_rvalid == $past(cpu_rd);
    endproperty
    a_rd_answer: assert property (p_rd_answer) // RQ6
        else $error("read answer not one cycle after strobe");

    // Mapped read returns the register as it stood
    property p_rd_data;
        @(posedge clock) disable iff (rst)
        (cpu_rd && wsel.hit) |=> (cpu_rdata == $past(regs_q[wsel.ch]));
    endproperty
    a_rd_data: assert property (p_rd_data) // RQ6
        else $error("read data differs from register");

    // Unmapped read answers zero
    property p_rd_miss;
        @(posedge clock) disable iff (rst)
        (cpu_rd && !wsel.hit) |=> (cpu_rdata == 8'h00);
    endproperty
    a_rd_miss: assert property (p_rd_miss) // RQ6
        else $error("unmapped read returned nonzero");

    // Idle read port holds zero
    property p_rd_idle;
        @(posedge clock) disable iff (rst)
        !cpu_rvalid |-> (cpu_rdata == 8'h00);
    endproperty
    a_rd_idle: assert property (p_rd_idle) // RQ6
        else $error("read data nonzero without answer");

    // Reserved positions never read back

    property p_rsv_zero;
        @(posedge clock) disable iff (rst)
        cpu_rvalid |-> ((cpu_rdata & ~TXM_WR_MASK) == 8'h00);
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) // RQ7
        else $error("reserved bits read nonzero");

endmodule

/* File: txm_tx_ctrl_tb.sv */
// Purpose: Self-checking bench for the transmit control register bank
// Assumes: Host strobes one cycle wide; inputs driven on rising edges
// Notes:   Drive monitor exercised on channel 0, error insert on ch 6
`timescale 1ns/1ps

module txm_tx_ctrl_tb
    import txm_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                    clock;       // System clock
    logic                    rst;         // Synchronous reset
    logic [TXM_AW-1:0]       cpu_addr;    // Host address
    logic                    cpu_wr;      // Write strobe
    logic                    cpu_rd;      // Read strobe
    logic [TXM_DW-1:0]       cpu_wdata;   // Write data
    logic [TXM_DW-1:0]       cpu_rdata;   // Read data
    logic                    cpu_rvalid;  // Read answer strobe
    logic [TXM_NCH-1:0]      gen_en;      // Pattern generator enables
    logic [TXM_NCH-1:0]      rx_en;       // Pattern receiver enables
    logic [TXM_NCH-1:0]      bit_en;      // Bit period markers
    logic [TXM_NCH-1:0]      pad_pos;     // Own pad, positive
    logic [TXM_NCH-1:0]      pad_neg;     // Own pad, negative
    logic [TXM_NCH-1:0]      mon_pos;     // Monitor pin, positive
    logic [TXM_NCH-1:0]      mon_neg;     // Monitor pin, negative
    logic [TXM_NCH-1:0]      alarm;       // Drive monitor alarms
    logic [TXM_NCH-1:0]      inject;      // Error insert pulses
    logic [TXM_NCH-1:0][2:0] low_bits;    // Low register bits
    int                      fail_count;  // Mismatches
    int                      comparisons; // Compares made
    // Addresses outside the map
    logic [7:0] ch_addr_list [6] = '{8'h64, 8'h74, 8'he4, 8'hf4,
                                     8'h05, 8'h03};

    // ------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------
    txm_tx_ctrl i_txm_tx_ctrl (
        .clock(clock), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .prbs_gen_en(gen_en), .prbs_rx_en(rx_en),
        .bit_en(bit_en), .tx_line_out_pos(pad_pos),
        .tx_line_out_neg(pad_neg), .monitor_in_pos(mon_pos),
        .monitor_in_neg(mon_neg), .driver_monitor_alarm(alarm),
        .prbs_err_inject(inject), .tx_ctrl_low(low_bits));

    // Free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input string n, input logic [11:0] e,
                       input logic [11:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Register address of a channel
    function automatic logic [7:0] ch_addr(input int i);
        logic [3:0] nib;
        nib = (i < 6) ? 4'(i) : 4'(i + 2);
        return {nib, TXM_TC_LOW};
    endfunction

    // One host write; returns just after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge clock);
        cpu_wr    <= 1'b0;
        #1;
    endtask

    // One host read with expected data
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge clock);
        cpu_rd   <= 1'b0;
        #1;
        chk("rvalid", 12'h001, {11'h000, cpu_rvalid});
        chk("rdata", {4'h0, e}, {4'h0, cpu_rdata});
    endtask

    // Bit period markers on channel 0
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            bit_en <= 12'h001;
            @(posedge clock);
            bit_en <= 12'h000;
        end
        repeat (2) @(posedge clock);
        #1;
    endtask

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        comparisons = 0;
        rst = 1'b1;
        cpu_addr = 8'h00;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_wdata = 8'h00;
        gen_en = '0;
        rx_en = '0;
        bit_en = '0;
        pad_pos = '0;
        pad_neg = '0;
        mon_pos = '0;
        mon_neg = '0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        // Map, reset value, reserved bits on every channel
        for (int i = 0; i < TXM_NCH; i++) begin
            rd_chk(ch_addr(i), TXM_TC_RESET);
            wr(ch_addr(i), 8'hff);
            chk("low bits", 12'h007, {9'h000, low_bits[i]});
            rd_chk(ch_addr(i), 8'h37);
        end
        // Unmapped places answer zero and store nothing
        foreach (ch_addr_list[k]) begin
            wr(ch_addr_list[k], 8'h00);
            rd_chk(ch_addr_list[k], 8'h00);
        end
        // Mapped registers untouched by those writes
        for (int i = 0; i < TXM_NCH; i++) begin
            rd_chk(ch_addr(i), TXM_WR_MASK);
        end
        $display("test register map done");
        // Error insert on channel 6
        @(posedge clock);
        gen_en <= '1;
        rx_en <= '1;
        wr(8'h84, 8'h00);
        wr(8'h84, 8'h10);
        chk("inject rise", 12'h040, inject);
        @(posedge clock);
        #1;
        chk("inject one bit", 12'h000, inject);
        wr(8'h84, 8'h10);
        chk("inject repeat", 12'h000, inject);
        wr(8'h84, 8'h00);
        wr(8'h84, 8'h10);
        chk("inject rearmed", 12'h040, inject);
        wr(8'h84, 8'h00);
        @(posedge clock);
        gen_en <= 12'hfbf;
        wr(8'h84, 8'h10);
        chk("inject gen off", 12'h000, inject);
        @(posedge clock);
        gen_en <= '1;
        repeat (2) @(posedge clock);
        #1;
        chk("inject late", 12'h000, inject);
        wr(8'h84, 8'h00);
        @(posedge clock);
        rx_en <= 12'hfbf;
        wr(8'h84, 8'h10);
        chk("inject rx off", 12'h000, inject);
        $display("test error insert done");
        // Drive monitor, internal mode, monitor pins busy
        wr(8'h04, 8'h20);
        @(posedge clock);
        mon_pos <= '1;
        pulses(127);
        chk("alarm early", 12'h000, {11'h000, alarm[0]});
        pulses(1);
        chk("alarm set", 12'h001, {11'h000, alarm[0]});
        @(posedge clock);
        pad_neg <= 12'h001;
        repeat (4) @(posedge clock);
        pad_neg <= '0;
        pulses(1);
        chk("alarm clear", 12'h000, {11'h000, alarm[0]});
        // External mode follows the monitor pins
        wr(8'h04, 8'h00);
        pulses(130);
        chk("alarm ext busy", 12'h000, {11'h000, alarm[0]});
        @(posedge clock);
        mon_pos <= '0;
        repeat (4) @(posedge clock);
        pulses(1);
        pulses(128);
        chk("alarm ext quiet", 12'h001, {11'h000, alarm[0]});
        $display("test drive monitor done");
        tally_and_finish();
    end

endmodule
